// ==== shared/bsc_pkg.sv ====
// constants, register map and types of the breaker synchronism check
package bsc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_100MS_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int FAIL_MS = 200;
    localparam int FAIL_PULSE_CYC = CLK_HZ / 1000 * FAIL_MS;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VLIM = 8'h04;
    localparam logic [7:0] ADDR_FLIM = 8'h08;
    localparam logic [7:0] ADDR_TIME = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // register field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_VCHK_LSB = 2;
    localparam int CTRL_PAIR_LSB = 5;
    localparam int CTRL_STAGE_BIT = 7;
    localparam int CTRL_PN_LSB = 8;
    localparam int VLIM_DEAD_LSB = 0;
    localparam int VLIM_LIVE_LSB = 8;
    localparam int VLIM_VDIF_LSB = 16;
    localparam int FLIM_SLIP_LSB = 0;
    localparam int FLIM_ANG_LSB = 16;
    localparam int TIME_CB_LSB = 0;
    localparam int TIME_TO_LSB = 16;

    // values after reset
    localparam logic [7:0] RST_DEAD = 8'h14;
    localparam logic [7:0] RST_LIVE = 8'h50;
    localparam logic [7:0] RST_VDIF = 8'h0A;
    localparam logic [6:0] RST_SLIP = 7'h0A;
    localparam logic [6:0] RST_ANG = 7'h14;
    localparam logic [9:0] RST_CB = 10'h064;
    localparam logic [12:0] RST_TO = 13'h0064;

    // setting ranges
    localparam int CB_MIN = 40;
    localparam int CB_MAX = 600;
    localparam int LIM_MIN = 10;
    localparam int LIM_MAX = 120;
    localparam int SLIP_MIN = 1;
    localparam int SLIP_MAX = 100;
    localparam int VDIF_MIN = 1;
    localparam int VDIF_MAX = 60;
    localparam int ANG_MIN = 2;
    localparam int ANG_MAX = 90;
    localparam int TO_MIN = 1;
    localparam int TO_MAX = 6000;

    // measurement arithmetic, angles in 0.1 degree, frequency in mHz
    localparam int RESET_RATIO_PCT = 97;
    localparam int SQRT3_MUL = 443;
    localparam int SQRT3_SHIFT = 8;
    localparam int PN_TO_LL_ANG = 300;
    localparam int ANG_FULL = 3600;
    localparam int ANG_HALF = 1800;
    localparam int ANG_TOL_FINE = 20;
    localparam int ANG_TOL_COARSE = 50;
    localparam int SLIP_FINE_MHZ = 200;
    localparam int SLIP_UNIT_MHZ = 10;
    localparam int ANG_UNIT = 10;
    localparam int ROT_MUL = 30199;
    localparam int ROT_SHIFT = 23;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_ASYNC,
        MODE_SYNC
    } bsc_mode_t;

    typedef enum logic [2:0] {
        VC_DD,
        VC_DL,
        VC_LD,
        VC_DD_DL,
        VC_DD_LD,
        VC_DL_LD,
        VC_ALL
    } bsc_vchk_t;

    typedef enum logic [1:0] {
        PAIR_LOC_Y,
        PAIR_LOC_Z,
        PAIR_Y_Z
    } bsc_pair_t;
endpackage : bsc_pkg

// ==== rtl/bsc_level.sv ====
// dead and live detector of one voltage channel
`timescale 1ns/1ps
module bsc_level import bsc_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // measurement and limits in percent of nominal
    input wire logic [7:0] mag,
    input wire logic [7:0] dead_lim,
    input wire logic [7:0] live_lim,
    // state
    output logic dead_r,
    output logic live_r
);
    logic [15:0] mag_pct;
    logic [15:0] drop_lvl;

    assign mag_pct = 16'(mag) * 16'd100;
    assign drop_lvl = 16'(live_lim) * 16'(RESET_RATIO_PCT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_r <= 1'b0;
        end else begin
            dead_r <= mag < dead_lim;
        end
    end

    // live drops only below the reset ratio, so noise near the limit
    // cannot make the ok output chatter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_r <= 1'b0;
        end else if (mag > live_lim) begin
            live_r <= 1'b1;
        end else if (mag_pct < drop_lvl) begin
            live_r <= 1'b0;
        end
    end
endmodule : bsc_level

// ==== rtl/bsc_synccheck.sv ====
// breaker synchronism check with two stages and apb settings
// Operation
// - local quantity is always line voltage one-two
// - stage one compares local with second channel
// - stage two pair selectable among three options
// - phase-neutral inputs converted to line-equivalent values
// - off mode uses voltage check only
// - async uses slip, voltage, angle limit criteria
// - async close advanced by slip and closing time
// - sync uses all criteria aiming zero angle
// - sync advance makes contact at zero angle
// - seven voltage codes, any listed combination passes
// - first letter reference, second comparison side
// - dead only below dead limit
// - live above live limit, held until below 97 percent of it
// - stage one reference local, comparison second channel
// - angle tolerance two degrees, five above slip
// - request active from start until ok or timeout
// - timeout gives fixed fail pulse, no close
// - synchronism needs both live and three criteria
// - bypass forces synchronism declared
`timescale 1ns/1ps
module bsc_synccheck import bsc_pkg::*; #(
    parameter int TICK_CYC = TICK_100MS_CYC,
    parameter int FAIL_CYC = FAIL_PULSE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements: magnitude %, angle 0.1 deg, frequency mHz
    input wire logic [7:0] local_line_voltage_mag,
    input wire logic [11:0] local_line_voltage_ang,
    input wire logic [15:0] local_line_voltage_freq,
    input wire logic [7:0] second_channel_line_voltage_mag,
    input wire logic [11:0] second_channel_line_voltage_ang,
    input wire logic [15:0] second_channel_line_voltage_freq,
    input wire logic [7:0] third_channel_line_voltage_mag,
    input wire logic [11:0] third_channel_line_voltage_ang,
    input wire logic [15:0] third_channel_line_voltage_freq,
    // pins from the close-command source
    input wire logic close_req,
    input wire logic bypass,
    // outputs
    output logic sync_request,
    output logic sync_fail,
    output logic sync_ok_s1,
    output logic sync_ok_s2,
    output logic cb_close
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_FAIL
    } bsc_state_t;

    // settings
    bsc_mode_t mode_r;
    bsc_vchk_t vchk_r;
    bsc_pair_t pair_r;
    logic stage_r;
    logic [2:0] pn_r;
    logic [7:0] dead_r;
    logic [7:0] live_r;
    logic [7:0] vdif_r;
    logic [6:0] slip_r;
    logic [6:0] ang_r;
    logic [9:0] cb_r;
    logic [12:0] to_r;

    logic [31:0] rd_nxt;
    logic err_nxt;
    logic wr_en;
    logic [1:0] req_sync_r;
    logic [1:0] byp_sync_r;
    logic req_d_r;

    logic [7:0] in_mag [3];
    logic [11:0] in_ang [3];
    logic [15:0] in_frq [3];
    logic [7:0] mag_r [3];
    logic [11:0] ang_r3 [3];
    logic [15:0] frq_r [3];
    logic [2:0] is_dead;
    logic [2:0] is_live;
    logic ok1_nxt;
    logic ok2_nxt;
    logic [1:0] s2_ref;
    logic [1:0] s2_cmp;

    bsc_state_t state_r;
    logic [31:0] tick_r;
    logic [12:0] to_cnt_r;
    logic [31:0] fail_cnt_r;
    logic sel_ok;

    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input int lo, input int hi);
        if (v < 16'(lo)) begin
            return 16'(lo);
        end else if (v > 16'(hi)) begin
            return 16'(hi);
        end
        return v;
    endfunction : clamp

    // ---------------- apb ----------------
    assign wr_en = psel & penable & pready & pwrite;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (paddr == ADDR_CTRL) begin
            rd_nxt[CTRL_MODE_LSB +: 2] = mode_r;
            rd_nxt[CTRL_VCHK_LSB +: 3] = vchk_r;
            rd_nxt[CTRL_PAIR_LSB +: 2] = pair_r;
            rd_nxt[CTRL_STAGE_BIT] = stage_r;
            rd_nxt[CTRL_PN_LSB +: 3] = pn_r;
        end else if (paddr == ADDR_VLIM) begin
            rd_nxt[VLIM_DEAD_LSB +: 8] = dead_r;
            rd_nxt[VLIM_LIVE_LSB +: 8] = live_r;
            rd_nxt[VLIM_VDIF_LSB +: 8] = vdif_r;
        end else if (paddr == ADDR_FLIM) begin
            rd_nxt[FLIM_SLIP_LSB +: 7] = slip_r;
            rd_nxt[FLIM_ANG_LSB +: 7] = ang_r;
        end else if (paddr == ADDR_TIME) begin
            rd_nxt[TIME_CB_LSB +: 10] = cb_r;
            rd_nxt[TIME_TO_LSB +: 13] = to_r;
        end else if (paddr == ADDR_STAT) begin
            rd_nxt = {21'h0, is_dead, is_live, cb_close, sync_ok_s2,
                      sync_ok_s1, sync_fail, sync_request};
        end else begin
            err_nxt = 1'b1;
        end
    end

    // one wait-free access: answer prepared during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            prdata <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
            pslverr <= psel & ~penable & err_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_OFF;
            vchk_r <= VC_DL;
            pair_r <= PAIR_LOC_Y;
            stage_r <= 1'b0;
            pn_r <= 3'h0;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            // unknown codes are kept out so decoding stays total
            if (pwdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
                mode_r <= bsc_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            end
            if (pwdata[CTRL_VCHK_LSB +: 3] != 3'h7) begin
                vchk_r <= bsc_vchk_t'(pwdata[CTRL_VCHK_LSB +: 3]);
            end
            if (pwdata[CTRL_PAIR_LSB +: 2] != 2'h3) begin
                pair_r <= bsc_pair_t'(pwdata[CTRL_PAIR_LSB +: 2]);
            end
            stage_r <= pwdata[CTRL_STAGE_BIT];
            pn_r <= pwdata[CTRL_PN_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_r <= RST_DEAD;
            live_r <= RST_LIVE;
            vdif_r <= RST_VDIF;
            slip_r <= RST_SLIP;
            ang_r <= RST_ANG;
            cb_r <= RST_CB;
            to_r <= RST_TO;
        end else if (wr_en && paddr == ADDR_VLIM) begin
            dead_r <= 8'(clamp(16'(pwdata[VLIM_DEAD_LSB +: 8]),
                               LIM_MIN, LIM_MAX));
            live_r <= 8'(clamp(16'(pwdata[VLIM_LIVE_LSB +: 8]),
                               LIM_MIN, LIM_MAX));
            vdif_r <= 8'(clamp(16'(pwdata[VLIM_VDIF_LSB +: 8]),
                               VDIF_MIN, VDIF_MAX));
        end else if (wr_en && paddr == ADDR_FLIM) begin
            slip_r <= 7'(clamp(16'(pwdata[FLIM_SLIP_LSB +: 7]),
                               SLIP_MIN, SLIP_MAX));
            ang_r <= 7'(clamp(16'(pwdata[FLIM_ANG_LSB +: 7]),
                              ANG_MIN, ANG_MAX));
        end else if (wr_en && paddr == ADDR_TIME) begin
            cb_r <= 10'(clamp(16'(pwdata[TIME_CB_LSB +: 10]),
                              CB_MIN, CB_MAX));
            to_r <= 13'(clamp(16'(pwdata[TIME_TO_LSB +: 13]),
                              TO_MIN, TO_MAX));
        end
    end

    // ---------------- pin synchronisers ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_sync_r <= 2'b00;
            byp_sync_r <= 2'b00;
            req_d_r <= 1'b0;
        end else begin
            req_sync_r <= {req_sync_r[0], close_req};
            byp_sync_r <= {byp_sync_r[0], bypass};
            req_d_r <= req_sync_r[1];
        end
    end

    // ---------------- measurement conditioning ----------------
    assign in_mag[0] = local_line_voltage_mag;
    assign in_mag[1] = second_channel_line_voltage_mag;
    assign in_mag[2] = third_channel_line_voltage_mag;
    assign in_ang[0] = local_line_voltage_ang;
    assign in_ang[1] = second_channel_line_voltage_ang;
    assign in_ang[2] = third_channel_line_voltage_ang;
    assign in_frq[0] = local_line_voltage_freq;
    assign in_frq[1] = second_channel_line_voltage_freq;
    assign in_frq[2] = third_channel_line_voltage_freq;

    // phase-neutral channels carry phase one: scale by root three and
    // shift by thirty degrees to get the line one-two equivalent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                mag_r[i] <= 8'h00;
                ang_r3[i] <= 12'h000;
                frq_r[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                frq_r[i] <= in_frq[i];
                if (pn_r[i]) begin
                    mag_r[i] <= ((17'(in_mag[i]) * 17'(SQRT3_MUL))
                                 >> SQRT3_SHIFT) > 17'h000FF ? 8'hFF :
                                8'(((17'(in_mag[i]) * 17'(SQRT3_MUL))
                                   >> SQRT3_SHIFT));
                    ang_r3[i] <= (13'(in_ang[i]) + 13'(PN_TO_LL_ANG))
                                 >= 13'(ANG_FULL) ?
                                 12'(13'(in_ang[i]) + 13'(PN_TO_LL_ANG)
                                     - 13'(ANG_FULL)) :
                                 12'(13'(in_ang[i]) +
                                     13'(PN_TO_LL_ANG));
                end else begin
                    mag_r[i] <= in_mag[i];
                    ang_r3[i] <= in_ang[i];
                end
            end
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_lvl
        bsc_level u_lvl (
            .pclk(pclk),
            .presetn(presetn),
            .mag(mag_r[g]),
            .dead_lim(dead_r),
            .live_lim(live_r),
            .dead_r(is_dead[g]),
            .live_r(is_live[g])
        );
    end

    // ---------------- synchronism evaluation ----------------
    function automatic logic eval(input logic [1:0] r, input logic [1:0] c);
        logic vok;
        logic fok;
        logic signed [16:0] df;
        logic [16:0] adf;
        logic signed [9:0] dv;
        logic signed [13:0] d;
        logic signed [47:0] rot;
        logic signed [13:0] p;
        logic [13:0] ap;
        logic [13:0] tol;
        // first letter reference side, second comparison side
        case (vchk_r)
            VC_DD: vok = is_dead[r] & is_dead[c];
            VC_DL: vok = is_dead[r] & is_live[c];
            VC_LD: vok = is_live[r] & is_dead[c];
            VC_DD_DL: vok = is_dead[r] & (is_dead[c] | is_live[c]);
            VC_DD_LD: vok = (is_dead[r] | is_live[r]) & is_dead[c];
            VC_DL_LD: vok = (is_dead[r] & is_live[c]) |
                            (is_live[r] & is_dead[c]);
            VC_ALL: vok = (is_dead[r] & (is_dead[c] | is_live[c])) |
                          (is_live[r] & is_dead[c]);
            default: vok = 1'b0;
        endcase
        df = $signed({1'b0, frq_r[r]}) - $signed({1'b0, frq_r[c]});
        adf = df < 0 ? 17'(-df) : 17'(df);
        dv = $signed({2'b00, mag_r[r]}) - $signed({2'b00, mag_r[c]});
        d = $signed({2'b00, ang_r3[r]}) - $signed({2'b00, ang_r3[c]});
        if (d >= 14'(ANG_HALF)) begin
            d = d - 14'(ANG_FULL);
        end else if (d < -14'(ANG_HALF)) begin
            d = d + 14'(ANG_FULL);
        end
        // angle the pair turns through while the breaker closes
        rot = (48'(df) * 48'($signed({1'b0, cb_r})) * 48'(ROT_MUL))
              >>> ROT_SHIFT;
        p = d + 14'(rot);
        if (p >= 14'(ANG_HALF)) begin
            p = p - 14'(ANG_FULL);
        end else if (p < -14'(ANG_HALF)) begin
            p = p + 14'(ANG_FULL);
        end
        ap = p < 0 ? 14'(-p) : 14'(p);
        tol = adf < 17'(SLIP_FINE_MHZ) ? 14'(ANG_TOL_FINE) :
              14'(ANG_TOL_COARSE);
        fok = is_live[r] & is_live[c] &
              (adf <= 17'(slip_r) * 17'(SLIP_UNIT_MHZ)) &
              ((dv < 0 ? 10'(-dv) : 10'(dv)) <= 10'(vdif_r));
        if (mode_r == MODE_ASYNC) begin
            fok = fok & (ap <= 14'(ang_r) * 14'(ANG_UNIT));
        end else if (mode_r == MODE_SYNC) begin
            fok = fok & (ap <= tol) &
                  (ap <= 14'(ang_r) * 14'(ANG_UNIT));
        end else begin
            fok = 1'b0;
        end
        return vok | fok;
    endfunction : eval

    always_comb begin
        s2_ref = 2'd0;
        s2_cmp = 2'd1;
        if (pair_r == PAIR_LOC_Z) begin
            s2_cmp = 2'd2;
        end else if (pair_r == PAIR_Y_Z) begin
            s2_ref = 2'd1;
            s2_cmp = 2'd2;
        end
        ok1_nxt = byp_sync_r[1] | eval(2'd0, 2'd1);
        ok2_nxt = byp_sync_r[1] | eval(s2_ref, s2_cmp);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ok_s1 <= 1'b0;
            sync_ok_s2 <= 1'b0;
        end else begin
            sync_ok_s1 <= ok1_nxt;
            sync_ok_s2 <= ok2_nxt;
        end
    end

    assign sel_ok = stage_r ? sync_ok_s2 : sync_ok_s1;

    // ---------------- close request sequence ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            sync_request <= 1'b0;
            sync_fail <= 1'b0;
            cb_close <= 1'b0;
            tick_r <= 32'h0000_0000;
            to_cnt_r <= 13'h0000;
            fail_cnt_r <= 32'h0000_0000;
        end else begin
            cb_close <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    tick_r <= 32'h0000_0000;
                    to_cnt_r <= 13'h0000;
                    if (req_sync_r[1] && !req_d_r) begin
                        state_r <= ST_WAIT;
                        sync_request <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (sel_ok) begin
                        state_r <= ST_IDLE;
                        sync_request <= 1'b0;
                        cb_close <= 1'b1;
                    end else if (to_cnt_r >= to_r) begin
                        // timed out: no close is issued
                        state_r <= ST_FAIL;
                        sync_request <= 1'b0;
                        sync_fail <= 1'b1;
                        fail_cnt_r <= 32'h0000_0000;
                    end else if (tick_r == 32'(TICK_CYC - 1)) begin
                        tick_r <= 32'h0000_0000;
                        to_cnt_r <= to_cnt_r + 13'h0001;
                    end else begin
                        tick_r <= tick_r + 32'h0000_0001;
                    end
                end
                ST_FAIL: begin
                    // requests during the fail pulse are ignored
                    if (fail_cnt_r == 32'(FAIL_CYC - 1)) begin
                        state_r <= ST_IDLE;
                        sync_fail <= 1'b0;
                    end else begin
                        fail_cnt_r <= fail_cnt_r + 32'h0000_0001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    sync_request <= 1'b0;
                    sync_fail <= 1'b0;
                end
            endcase
        end
    end
endmodule : bsc_synccheck

// ==== verification/bsc_synccheck_properties.sv ====
// port assertions of the breaker synchronism check
`timescale 1ns/1ps
module bsc_synccheck_checker #(
    parameter int FAIL_CYC = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic bypass,
    input wire logic sync_request,
    input wire logic sync_fail,
    input wire logic sync_ok_s1,
    input wire logic sync_ok_s2,
    input wire logic cb_close
);
    default clocking dclk @(posedge pclk); endclocking
    default disable iff (!presetn);
    // length of the running fail pulse, compared when it drops
    logic [31:0] fail_len_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fail_len_r <= 32'h0;
        else fail_len_r <= sync_fail ? fail_len_r + 32'h1 : 32'h0;
    end
    // bypass must cross a two-flop synchroniser and the ok register
    sequence s_bypass_held;
        bypass [*5];
    endsequence
    sequence s_req_ended;
        $past(sync_request) && !sync_request;
    endsequence
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_bypass_ok: assert property (
        s_bypass_held |-> sync_ok_s1 && sync_ok_s2)
        else $error("ok low while bypass held");
    a_close_single: assert property (cb_close |=> !cb_close)
        else $error("close longer than one cycle");
    a_close_ends_req: assert property (cb_close |-> s_req_ended)
        else $error("close without ending request");
    a_close_after_ok: assert property (
        cb_close |-> $past(sync_ok_s1 | sync_ok_s2))
        else $error("close without stage ok");
    a_fail_no_close: assert property (
        sync_fail |-> !cb_close && !sync_request)
        else $error("close or request during fail");
    a_fail_from_req: assert property (
        $rose(sync_fail) |-> s_req_ended)
        else $error("fail not ending a request");
    a_fail_width: assert property (
        $fell(sync_fail) |-> fail_len_r == FAIL_CYC)
        else $error("fail pulse length wrong");
endmodule : bsc_synccheck_checker

bind bsc_synccheck bsc_synccheck_checker #(.FAIL_CYC(FAIL_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bypass(bypass),
    .sync_request(sync_request), .sync_fail(sync_fail),
    .sync_ok_s1(sync_ok_s1), .sync_ok_s2(sync_ok_s2), .cb_close(cb_close)
);

// ==== verification/bsc_far_model.sv ====
// close-command source and breaker object model
`timescale 1ns/1ps
module bsc_far_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from bench and block
    input wire logic start,
    input wire logic cb_close,
    // to block and bench
    output logic close_req,
    output logic [7:0] n_close
);
    // bench holds start long enough for the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) close_req <= 1'b0;
        else close_req <= start;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) n_close <= 8'h00;
        else if (cb_close) n_close <= n_close + 8'h01;
    end
endmodule : bsc_far_model

// ==== verification/tb.sv ====
// self-checking bench for the breaker synchronism check
`timescale 1ns/1ps
module tb import bsc_pkg::*;;
    localparam logic [2:0] VC_OK [7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6,
        3'h7};
    localparam logic [1:0] MD [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
    localparam logic [11:0] AN [4] = '{12'h12C, 12'h064, 12'h01E, 12'h00A};
    localparam logic [7:0] HM [5] = '{8'h64, 8'h4E, 8'h4D, 8'h14, 8'h13};
    localparam logic [1:0] HX [5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, bypass = 1'b0, start = 1'b0, rerr;
    logic [7:0] paddr = 8'h00, lm = 8'h64, sm = 8'h64, tm = 8'h0A, n_close;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [11:0] la = 12'h000, sa = 12'h000;
    logic [15:0] fq = 16'hC350;
    logic pready, pslverr, close_req, sync_request, sync_fail;
    logic sync_ok_s1, sync_ok_s2, cb_close;
    int err_count = 0, n_compared = 0, cyc = 0;
    always #5 pclk = ~pclk;
    bsc_synccheck #(.TICK_CYC(10), .FAIL_CYC(20)) uut (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .local_line_voltage_mag(lm),
        .local_line_voltage_ang(la), .local_line_voltage_freq(fq),
        .second_channel_line_voltage_mag(sm),
        .second_channel_line_voltage_ang(sa),
        .second_channel_line_voltage_freq(fq),
        .third_channel_line_voltage_mag(tm),
        .third_channel_line_voltage_ang(la),
        .third_channel_line_voltage_freq(fq), .close_req(close_req),
        .bypass(bypass), .sync_request(sync_request), .sync_fail(sync_fail),
        .sync_ok_s1(sync_ok_s1), .sync_ok_s2(sync_ok_s2), .cb_close(cb_close));
    bsc_far_model far (.pclk(pclk), .presetn(presetn), .start(start),
        .cb_close(cb_close), .close_req(close_req), .n_close(n_close));
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask : settle
    task automatic pulse_req;
        @(posedge pclk);
        start <= 1'b1;
        repeat (3) @(posedge pclk);
        start <= 1'b0;
    endtask : pulse_req
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ADDR_CTRL, 0); check("ctrl", rd, 32'h4);
        apb(0, ADDR_VLIM, 0); check("vlim", rd, 32'h000A5014);
        apb(0, ADDR_FLIM, 0); check("flim", rd, 32'h0014000A);
        apb(0, ADDR_TIME, 0); check("time", rd, 32'h00640064);
        apb(0, 8'h20, 0); check("unmapped", {rd[30:0], rerr}, 32'h1);
        apb(1, ADDR_VLIM, 32'h00FF0505); apb(0, ADDR_VLIM, 0);
        check("vlim clamp", rd, 32'h003C0A0A);
        apb(1, ADDR_FLIM, 32'h007F0000); apb(0, ADDR_FLIM, 0);
        check("flim clamp", rd, 32'h005A0001);
        apb(1, ADDR_VLIM, 32'h000A5014); apb(1, ADDR_FLIM, 32'h0014000A);
        // local is reference, second channel comparison
        for (int c = 0; c < 7; c++) begin
            apb(1, ADDR_CTRL, 32'(c) << 2);
            for (int k = 0; k < 4; k++) begin
                lm <= k[1] ? 8'h64 : 8'h0A; sm <= k[0] ? 8'h64 : 8'h0A;
                settle();
                check("code", 32'(sync_ok_s1),
                    32'(k < 3 && VC_OK[c][k]));
            end
        end
        for (int i = 0; i < 5; i++) begin
            lm <= HM[i]; settle(); apb(0, ADDR_STAT, 0);
            check("lvl", 32'({rd[8], rd[5]}), 32'(HX[i]));
        end
        apb(1, ADDR_CTRL, 32'h24); lm <= 8'h0A; sm <= 8'h0A; tm <= 8'h64;
        settle();
        check("pair", 32'({sync_ok_s2, sync_ok_s1}), 32'h2);
        lm <= 8'h64; sm <= 8'h64;
        for (int i = 0; i < 4; i++) begin
            apb(1, ADDR_CTRL, 32'(MD[i])); sa <= AN[i]; settle();
            check("angle ok1", 32'(sync_ok_s1), 32'(i % 2));
        end
        apb(1, ADDR_CTRL, 32'h301); lm <= 8'h3A; sm <= 8'h3A; settle();
        check("pn", 32'(sync_ok_s1), 32'h1);
        sa <= 12'h12C; bypass <= 1'b1; settle();
        check("bypass", 32'({sync_ok_s2, sync_ok_s1}), 32'h3);
        pulse_req(); repeat (10) @(posedge pclk);
        check("close", 32'({n_close, sync_request}), 32'h2);
        bypass <= 1'b0;
        apb(1, ADDR_TIME, 32'h00010064); settle();
        pulse_req(); repeat (2) @(posedge pclk);
        check("request", 32'(sync_request), 32'h1);
        repeat (14) @(posedge pclk);
        check("fail", 32'({n_close, sync_fail}), 32'h3);
        repeat (30) @(posedge pclk);
        tally_and_finish();
    end
endmodule : tb
